//--- wcdm_defines.svh
`ifndef WCDM_DEFINES_SVH
`define WCDM_DEFINES_SVH

// ----------------------------------------------------------------
// Register indices on the software port
// ----------------------------------------------------------------
`define WCDM_A_MODE5    3'h0
`define WCDM_A_MODE1    3'h1
`define WCDM_A_READOUT3 3'h2
`define WCDM_A_STATUS   3'h3
`define WCDM_A_MASK     3'h4
`define WCDM_A_CTRL     3'h5

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define WCDM_M5_RINV    12
`define WCDM_M5_WINV    11
`define WCDM_M5_MASK    10
`define WCDM_M5_ERR     3
`define WCDM_M1_TERM    11
`define WCDM_R3_ERR     7
`define WCDM_CTRL_CRC   0
`define WCDM_ST_CRC     0
`define WCDM_ST_WRITE   1
`define WCDM_ST_DROP    2
`define WCDM_ST_CONF    3

// ----------------------------------------------------------------
// Organisation codes and timing counts
// ----------------------------------------------------------------
`define WCDM_ORG_X4     2'h0
`define WCDM_ORG_X8     2'h1
`define WCDM_ORG_X16    2'h2
`define WCDM_ALERT_MIN  4'h6
`define WCDM_ALERT_MAX  4'hA
`define WCDM_ALERT_LEN  4'h8
`define WCDM_LAST_BEAT  3'h7
`define WCDM_ZERO_LIMIT 4'h4

`endif

//--- wcdm_pkg.sv
package wcdm_pkg;

  // Write capture sequence
  typedef enum logic [1:0] {
    WS_IDLE = 2'b00,
    WS_BEAT = 2'b01,
    WS_DONE = 2'b10
  } wcdm_wstate_t;

  // One transfer on both byte lanes with their shared lane pins
  typedef struct packed {
    logic [15:0] dq;
    logic [1:0]  flag;
  } wcdm_beat_t;

endpackage : wcdm_pkg

//--- wcdm_lane_inv.sv
`timescale 1ns/1ps
`default_nettype none
`include "wcdm_defines.svh"

module wcdm_lane_inv (
  input  wire logic [7:0] byte_i,
  input  wire logic       ena,
  output var  logic [7:0] byte_o,
  output var  logic       flag_n_o
);

  // Count zeros, invert the byte when more than four would switch low
  always_comb begin
    logic [3:0] zeros;
    zeros = 4'h0;
    for (int i = 0; i < 8; i++) begin
      zeros = zeros + {3'h0, ~byte_i[i]};
    end
    flag_n_o = !(ena && (zeros > `WCDM_ZERO_LIMIT));
    byte_o   = flag_n_o ? byte_i : ~byte_i;
  end

endmodule : wcdm_lane_inv
`default_nettype wire

//--- wcdm_lane.sv
// Notes on behaviour
// [RULE1] Checksum error: alert low 6 to 10 cycles
// [RULE2] Error sets status and readout bit, held
// [RULE3] Controller clears error writing zero there
// [RULE4] Masking plus checksum: bad burst discarded
// [RULE5] Checksum without masking: bad burst written
// [RULE6] Narrowest organisation has no inversion, masking
// [RULE7] One lane pin, only one use active
// [RULE8] Controller avoids inversion with mask, readout
// [RULE9] Enable bits; inversion and masking exclusive
// [RULE10] Termination strobe only when others disabled
// [RULE11] Write flag low inverts the stored byte
// [RULE12] Eight write transfers, one flag each lane
// [RULE13] Read byte with over four zeros inverted
// [RULE14] Eight read transfers, flag per lane
// [RULE15] Mask acts only on writes
// [RULE16] Mask low drops byte, high writes it
// [RULE17] Controller retries writes after short alert
// [RULE18] Inversion decided per transfer, per lane
//
// Implementation choices: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "wcdm_defines.svh"

module wcdm_lane (
  input  wire logic                mclk,
  input  wire logic                reset_n,
  input  wire logic [2:0]          reg_addr,
  input  wire logic [15:0]         reg_wdata,
  input  wire logic                reg_wr,
  input  wire logic                reg_rd,
  output var  logic [15:0]         reg_rdata,
  input  wire logic [1:0]          org_sel,
  input  wire logic                link_clk,
  input  wire logic                link_frame,
  input  wire wcdm_pkg::wcdm_beat_t link_beat,
  input  wire logic                crc_mismatch,
  input  wire logic                mpr_read,
  input  wire logic                rd_valid,
  input  wire logic [15:0]         rd_data,
  output var  wcdm_pkg::wcdm_beat_t rd_out,
  output var  logic                rd_dq_oe,
  output var  logic [1:0]          rd_flag_oe,
  output var  logic                arr_we,
  output var  logic [127:0]        arr_data,
  output var  logic [15:0]         arr_be,
  output var  logic                alert_o,
  output var  logic                alert_oe,
  output var  logic                term_strobe_en,
  output var  logic                irq
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  // Strobe, frame, data and strap share one delay so they stay aligned
  // Layout: strap [21:20], strobe [19], frame [18], beat [17:0]
  logic [21:0] sy1_q;
  logic [21:0] sy2_q;
  logic        lclk_q;
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      sy1_q  <= 22'h0;
      sy2_q  <= 22'h0;
      lclk_q <= 1'b0;
    end else begin
      sy1_q  <= {org_sel, link_clk, link_frame, link_beat};
      sy2_q  <= sy1_q;
      lclk_q <= sy2_q[19];
    end
  end

  wcdm_pkg::wcdm_beat_t beat_s;
  logic                 frame_s;
  logic                 rise;
  logic [1:0]           org_s;
  assign beat_s  = sy2_q[17:0];
  assign frame_s = sy2_q[18];
  assign org_s   = sy2_q[21:20];
  assign rise    = sy2_q[19] && !lclk_q;

  // ----------------------------------------------------------------
  // Mode decode
  // ----------------------------------------------------------------
  logic [15:0] m5_q, m5_d, m1_q, m1_d, st_q, st_d;
  logic [15:0] msk_q, msk_d, ctl_q, ctl_d;
  logic x4, x8, mask_act, winv_act, rinv_act, term_act, conflict;

  // Mask wins no pin if both uses are requested at once
  assign x4       = (org_s == `WCDM_ORG_X4);
  assign x8       = (org_s == `WCDM_ORG_X8);
  assign mask_act = m5_q[`WCDM_M5_MASK] && !m5_q[`WCDM_M5_WINV]
                    && !x4;                          // [RULE6] [RULE9]
  assign winv_act = m5_q[`WCDM_M5_WINV] && !m5_q[`WCDM_M5_MASK]
                    && !x4;                          // [RULE6] [RULE9]
  assign rinv_act = m5_q[`WCDM_M5_RINV] && !x4
                    && !mpr_read;                    // [RULE8] [RULE6]
  assign term_act = m1_q[`WCDM_M1_TERM] && x8
                    && (m5_q[12:10] == 3'h0);        // [RULE10]
  assign conflict = (m5_q[`WCDM_M5_MASK] && m5_q[`WCDM_M5_WINV])
                    || (m1_q[`WCDM_M1_TERM]
                    && (m5_q[12:10] != 3'h0));       // [RULE9] [RULE10]

  // ----------------------------------------------------------------
  // Write capture and commit
  // ----------------------------------------------------------------
  wcdm_pkg::wcdm_wstate_t ws_q, ws_d;
  wcdm_pkg::wcdm_beat_t   buf_q [8];
  wcdm_pkg::wcdm_beat_t   buf_d [8];
  logic [2:0]   cnt_q, cnt_d;
  logic         we_q, we_d;
  logic [127:0] dat_q, dat_d;
  logic [15:0]  be_q, be_d;
  logic         crc_bad, ev_err, ev_write, ev_drop;

  assign crc_bad = (ws_q == wcdm_pkg::WS_DONE) && ctl_q[`WCDM_CTRL_CRC]
                   && crc_mismatch;

  // Burst of eight transfers per lane, one pin bit each
  always_comb begin
    ws_d     = ws_q;
    cnt_d    = cnt_q;
    buf_d    = buf_q;
    we_d     = 1'b0;
    dat_d    = dat_q;
    be_d     = be_q;
    ev_err   = 1'b0;
    ev_write = 1'b0;
    ev_drop  = 1'b0;
    case (ws_q)
      wcdm_pkg::WS_IDLE: begin
        cnt_d = 3'h0;
        if (frame_s && rise) begin
          buf_d[0] = beat_s;                         // [RULE12]
          cnt_d    = 3'h1;
          ws_d     = wcdm_pkg::WS_BEAT;
        end
      end
      wcdm_pkg::WS_BEAT: begin
        if (rise) begin
          buf_d[cnt_q] = beat_s;                     // [RULE12]
          cnt_d        = cnt_q + 3'h1;
          if (cnt_q == `WCDM_LAST_BEAT) begin
            ws_d = wcdm_pkg::WS_DONE;
          end
        end
      end
      wcdm_pkg::WS_DONE: begin
        ws_d   = wcdm_pkg::WS_IDLE;
        ev_err = crc_bad;
        for (int b = 0; b < 8; b++) begin
          for (int l = 0; l < 2; l++) begin
            dat_d[b*16+l*8 +: 8] = (winv_act && !buf_q[b].flag[l])
              ? ~buf_q[b].dq[l*8 +: 8]               // [RULE11]
              : buf_q[b].dq[l*8 +: 8];
            be_d[b*2+l] = !mask_act || buf_q[b].flag[l]; // [RULE16]
          end
        end
        // Masked mode must not commit a bad burst; plain mode does
        if (crc_bad && mask_act) begin
          ev_drop = 1'b1;                            // [RULE4]
        end else begin
          we_d     = 1'b1;                           // [RULE5]
          ev_write = 1'b1;
        end
      end
      default: begin
        ws_d = wcdm_pkg::WS_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      ws_q  <= wcdm_pkg::WS_IDLE;
      cnt_q <= 3'h0;
      we_q  <= 1'b0;
      dat_q <= 128'h0;
      be_q  <= 16'h0;
      for (int i = 0; i < 8; i++) begin
        buf_q[i] <= 18'h0;
      end
    end else begin
      ws_q  <= ws_d;
      cnt_q <= cnt_d;
      we_q  <= we_d;
      dat_q <= dat_d;
      be_q  <= be_d;
      buf_q <= buf_d;
    end
  end

  assign arr_we   = we_q;
  assign arr_data = dat_q;
  assign arr_be   = be_q;

  // ----------------------------------------------------------------
  // Alert pulse
  // ----------------------------------------------------------------
  logic [3:0] al_q, al_d;
  logic       aoe_q;
  // A new error while the pulse runs restarts it; longer is allowed
  always_comb begin
    al_d = (al_q != 4'h0) ? al_q - 4'h1 : 4'h0;
    if (ev_err) begin
      al_d = `WCDM_ALERT_LEN;                        // [RULE1]
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      al_q  <= 4'h0;
      aoe_q <= 1'b0;
    end else begin
      al_q  <= al_d;
      aoe_q <= (al_d != 4'h0);                       // [RULE1]
    end
  end

  // Open drain: only ever pulls low
  assign alert_o  = 1'b0;
  assign alert_oe = aoe_q;

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  logic [15:0] inv_dq;
  logic [1:0]  inv_fl;
  wcdm_lane_inv u_inv_lo (
    .byte_i   (rd_data[7:0]),
    .ena      (rinv_act),
    .byte_o   (inv_dq[7:0]),
    .flag_n_o (inv_fl[0])
  );
  wcdm_lane_inv u_inv_hi (
    .byte_i   (rd_data[15:8]),
    .ena      (rinv_act),
    .byte_o   (inv_dq[15:8]),
    .flag_n_o (inv_fl[1])
  );

  wcdm_pkg::wcdm_beat_t ro_q, ro_d;
  logic       doe_q;
  logic [1:0] foe_q, foe_d;
  logic       tse_q;
  // Each transfer and lane judged alone; mask never drives on reads
  always_comb begin
    ro_d.dq   = rd_valid ? inv_dq : 16'h0;           // [RULE13] [RULE18]
    ro_d.flag = rd_valid ? inv_fl : 2'h3;            // [RULE14]
    foe_d     = {2{rd_valid && rinv_act}}
                & {!x8, 1'b1};                       // [RULE15] [RULE7]
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      ro_q  <= 18'h3;
      doe_q <= 1'b0;
      foe_q <= 2'h0;
      tse_q <= 1'b0;
    end else begin
      ro_q  <= ro_d;
      doe_q <= rd_valid;
      foe_q <= foe_d;
      tse_q <= term_act;                             // [RULE7]
    end
  end

  assign rd_out         = ro_q;
  assign rd_dq_oe       = doe_q;
  assign rd_flag_oe     = foe_q;
  assign term_strobe_en = tse_q;

  // ----------------------------------------------------------------
  // Register port
  // ----------------------------------------------------------------
  logic [15:0] rdat_q, rdat_d;
  logic        irq_q;
  logic [15:0] st_set, w1c;
  logic        clr_err;

  assign st_set = {12'h0, conflict, ev_drop, ev_write, ev_err};
  assign w1c    = (reg_wr && reg_addr == `WCDM_A_STATUS)
                  ? reg_wdata : 16'h0;
  assign clr_err = reg_wr && (reg_addr == `WCDM_A_MODE5)
                   && !reg_wdata[`WCDM_M5_ERR];      // [RULE3]

  // Hardware set beats a clear in the same cycle
  always_comb begin
    m5_d  = m5_q;
    m1_d  = m1_q;
    msk_d = msk_q;
    ctl_d = ctl_q;
    if (reg_wr && reg_addr == `WCDM_A_MODE5) begin
      m5_d[12:10] = reg_wdata[12:10];                // [RULE9]
    end
    if (reg_wr && reg_addr == `WCDM_A_MODE1) begin
      m1_d[`WCDM_M1_TERM] = reg_wdata[`WCDM_M1_TERM]; // [RULE10]
    end
    if (reg_wr && reg_addr == `WCDM_A_MASK) begin
      msk_d = {12'h0, reg_wdata[3:0]};
    end
    if (reg_wr && reg_addr == `WCDM_A_CTRL) begin
      ctl_d = {15'h0, reg_wdata[`WCDM_CTRL_CRC]};
    end
    m5_d[`WCDM_M5_ERR] = ev_err
      || (m5_q[`WCDM_M5_ERR] && !clr_err);           // [RULE2] [RULE3]
    st_d   = st_set | (st_q & ~w1c);
    rdat_d = 16'h0;
    if (reg_rd) begin
      case (reg_addr)
        `WCDM_A_MODE5:    rdat_d = m5_q;
        `WCDM_A_MODE1:    rdat_d = m1_q;
        `WCDM_A_READOUT3: rdat_d = {8'h0, m5_q[`WCDM_M5_ERR],
                                    7'h0};           // [RULE2]
        `WCDM_A_STATUS:   rdat_d = st_q;
        `WCDM_A_MASK:     rdat_d = msk_q;
        `WCDM_A_CTRL:     rdat_d = ctl_q;
        default:          rdat_d = 16'h0;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      m5_q   <= 16'h0;
      m1_q   <= 16'h0;
      st_q   <= 16'h0;
      msk_q  <= 16'h0;
      ctl_q  <= 16'h0;
      rdat_q <= 16'h0;
      irq_q  <= 1'b0;
    end else begin
      m5_q   <= m5_d;
      m1_q   <= m1_d;
      st_q   <= st_d;
      msk_q  <= msk_d;
      ctl_q  <= ctl_d;
      rdat_q <= rdat_d;
      irq_q  <= |(st_d & msk_d);
    end
  end

  assign reg_rdata = rdat_q;
  assign irq       = irq_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);

  sequence s_err_seen;
    ws_q == wcdm_pkg::WS_DONE && ctl_q[`WCDM_CTRL_CRC] && crc_mismatch;
  endsequence
  sequence s_alert_pulse;
    alert_oe[*8] ##1 !alert_oe;
  endsequence

  chk_alert_pulse: assert property ( // [RULE1]
    s_err_seen |=> s_alert_pulse)
    else $error("alert pulse length wrong");
  chk_err_held: assert property ( // [RULE2]
    s_err_seen |=> m5_q[`WCDM_M5_ERR])
    else $error("error status not set");
  chk_err_keep: assert property ( // [RULE2]
    m5_q[`WCDM_M5_ERR] && !clr_err |=> m5_q[`WCDM_M5_ERR])
    else $error("error status not held");
  chk_err_mirror: assert property ( // [RULE2]
    reg_rd && reg_addr == `WCDM_A_READOUT3
    |=> reg_rdata[`WCDM_R3_ERR] == $past(m5_q[`WCDM_M5_ERR]))
    else $error("readout error bit differs");
  chk_err_clear: assert property ( // [RULE3]
    clr_err && !ev_err |=> !m5_q[`WCDM_M5_ERR])
    else $error("error status not cleared");
  chk_crc_drop: assert property ( // [RULE4]
    s_err_seen ##0 mask_act |=> !arr_we ##1 st_q[`WCDM_ST_DROP])
    else $error("bad masked burst committed");
  chk_crc_keep: assert property ( // [RULE5]
    s_err_seen ##0 !mask_act |=> arr_we)
    else $error("bad plain burst not written");
  chk_x4_quiet: assert property ( // [RULE6]
    x4 && rd_valid |=> rd_flag_oe == 2'h0 && rd_out.dq == $past(rd_data))
    else $error("narrow part inverted");
  chk_pin_single: assert property ( // [RULE7]
    !(term_strobe_en && (rd_flag_oe != 2'h0)))
    else $error("lane pin used twice");
  chk_write_inv: assert property ( // [RULE11]
    ws_q == wcdm_pkg::WS_DONE && winv_act && !buf_q[0].flag[0]
    |=> arr_data[7:0] == ~$past(buf_q[0].dq[7:0]))
    else $error("write inversion wrong");
  chk_read_inv: assert property ( // [RULE13]
    rd_flag_oe[0] |-> (!rd_out.flag[0]) ==
    ($countones(~$past(rd_data[7:0])) > 4))
    else $error("read inversion decision wrong");
  chk_mask_drop: assert property ( // [RULE16]
    ws_q == wcdm_pkg::WS_DONE && mask_act && !buf_q[3].flag[1]
    |=> !arr_be[7])
    else $error("masked byte enabled");

endmodule : wcdm_lane
`default_nettype wire

//--- wcdm_ctrl_model.sv
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------
// Controller side of the write link
// ----------------------------------------------
module wcdm_ctrl_model (
  input  wire logic                       go,
  input  wire wcdm_pkg::wcdm_beat_t [7:0] burst,
  output var  logic                       busy,
  output var  logic                       link_clk,
  output var  logic                       link_frame,
  output var  wcdm_pkg::wcdm_beat_t       link_beat
);
  initial begin
    busy       = 1'b0;
    link_clk   = 1'b0;
    link_frame = 1'b0;
    link_beat  = '0;
  end

  // Eight beats per burst; strobe clock only runs inside a frame
  always begin
    @(posedge go);
    busy       = 1'b1;
    link_frame = 1'b1;
    for (int i = 0; i < 8; i++) begin
      link_beat = burst[i];
      #62.5 link_clk = 1'b1;
      #62.5 link_clk = 1'b0;
    end
    // Released lines flip, so a stale beat never looks valid
    link_frame = 1'b0;
    link_beat  = ~link_beat;
    busy       = 1'b0;
  end
endmodule : wcdm_ctrl_model

`default_nettype wire

//--- test_wcdm_lane.sv
`timescale 1ns/1ps
`default_nettype none
`include "wcdm_defines.svh"

module test_wcdm_lane;
  logic                       mclk;
  logic                       reset_n;
  logic [2:0]                 reg_addr;
  logic [15:0]                reg_wdata;
  logic                       reg_wr;
  logic                       reg_rd;
  logic [15:0]                reg_rdata;
  logic [1:0]                 org_sel;
  logic                       link_clk;
  logic                       link_frame;
  wcdm_pkg::wcdm_beat_t       link_beat;
  logic                       crc_mismatch;
  logic                       mpr_read;
  logic                       rd_valid;
  logic [15:0]                rd_data;
  wcdm_pkg::wcdm_beat_t       rd_out;
  logic                       rd_dq_oe;
  logic [1:0]                 rd_flag_oe;
  logic                       arr_we;
  logic [127:0]               arr_data;
  logic [15:0]                arr_be;
  logic                       alert_o;
  logic                       alert_oe;
  logic                       term_strobe_en;
  logic                       irq;
  logic                       go;
  logic                       busy;
  wcdm_pkg::wcdm_beat_t [7:0] burst;
  logic [15:0]                vals [5];
  int                         mismatches = 0;
  int                         n_checks = 0;
  int                         cycles = 0;
  int                         n_we = 0;
  int                         run = 0;
  int                         last_alert = 0;

  wcdm_lane u_wcdm_lane (
    .mclk(mclk), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .org_sel(org_sel), .link_clk(link_clk),
    .link_frame(link_frame), .link_beat(link_beat),
    .crc_mismatch(crc_mismatch), .mpr_read(mpr_read),
    .rd_valid(rd_valid), .rd_data(rd_data), .rd_out(rd_out),
    .rd_dq_oe(rd_dq_oe), .rd_flag_oe(rd_flag_oe), .arr_we(arr_we),
    .arr_data(arr_data), .arr_be(arr_be), .alert_o(alert_o),
    .alert_oe(alert_oe), .term_strobe_en(term_strobe_en), .irq(irq)
  );

  wcdm_ctrl_model u_wcdm_ctrl_model (
    .go(go), .burst(burst), .busy(busy), .link_clk(link_clk),
    .link_frame(link_frame), .link_beat(link_beat)
  );

  // ----------------------------------------------
  // Clock, monitors and timeout
  // ----------------------------------------------
  initial mclk = 1'b0;
  always #5 mclk = ~mclk;

  // Commit pulses and alert width; a hang ends the run
  always @(posedge mclk) begin
    cycles = cycles + 1;
    if (arr_we === 1'b1)
      n_we = n_we + 1;
    if (alert_oe !== 1'b1 && run != 0)
      last_alert = run;
    run = (alert_oe === 1'b1) ? run + 1 : 0;
    if (cycles == 20000) begin
      mismatches = mismatches + 1;
      end_sim();
    end
  end

  // ----------------------------------------------
  // Shared tasks
  // ----------------------------------------------
  task automatic chk(input logic [127:0] seen, input logic [127:0] exp);
    n_checks = n_checks + 1;
    if (seen !== exp) begin
      mismatches = mismatches + 1;
      $display("MISMATCH at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    @(posedge mclk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask : wr

  // Read data only stands in the cycle after the strobe
  task automatic rd(input logic [2:0] a, input logic [15:0] e);
    @(posedge mclk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, e);
  endtask : rd

  // Over four zero bits means the lane goes out inverted, flag low
  function automatic logic [8:0] lane(input logic [7:0] b,
                                      input logic       en);
    int z;
    z = 8 - $countones(b);
    return (en && z > 4) ? {~b, 1'b0} : {b, 1'b1};
  endfunction : lane

  // Back-to-back read transfers, each checked one cycle later
  task automatic rdq(input logic en, input logic [1:0] foe);
    logic [8:0] h;
    logic [8:0] l;
    for (int i = 0; i <= 4; i++) begin
      @(posedge mclk);
      rd_valid <= (i < 4);
      rd_data  <= vals[i];
      #1;
      if (i > 0) begin
        h = lane(vals[i-1][15:8], en);
        l = lane(vals[i-1][7:0], en);
        chk({rd_out, rd_dq_oe, rd_flag_oe},
            {h[8:1], l[8:1], h[0], l[0], 1'b1, foe});
      end
    end
  endtask : rdq

  // One write burst; fl holds the lane pins, two bits per beat
  task automatic wb(input logic [15:0] fl, input logic bad,
                    input logic winv, input logic msk, input logic ok);
    logic [127:0] ed;
    logic [15:0]  dq;
    int           w0;
    for (int i = 0; i < 8; i++) begin
      dq = {4'hC, i[3:0], 4'h3, i[3:0]};
      burst[i] = {dq, fl[2*i +: 2]};
      ed[16*i +: 16] = dq ^ {{8{winv & ~fl[2*i+1]}}, {8{winv & ~fl[2*i]}}};
    end
    w0 = n_we;
    @(posedge mclk);
    crc_mismatch <= bad;
    go           <= 1'b1;
    @(posedge mclk);
    go <= 1'b0;
    for (int k = 0; k < 200 && busy === 1'b1; k++)
      @(posedge mclk);
    // The commit lands before busy drops; the alert pulse ends well inside this wait
    repeat (24) @(posedge mclk);
    #1;
    chk(n_we - w0, ok);
    if (ok) begin
      chk(arr_data, ed);
      chk(arr_be, msk ? fl : 16'hFFFF);
    end
  endtask : wb

  task automatic end_sim();
    $display("Checks %0d, mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : end_sim

  // ----------------------------------------------
  // Main sequence
  // ----------------------------------------------
  initial begin
    reset_n = 1'b0; reg_addr = 3'h0; reg_wdata = 16'h0000;
    reg_wr = 1'b0; reg_rd = 1'b0; org_sel = 2'h2; go = 1'b0;
    crc_mismatch = 1'b0; mpr_read = 1'b0; rd_valid = 1'b0;
    rd_data = 16'h0000; burst = '0;
    vals = '{16'h00FF, 16'h0F07, 16'hF0E0, 16'h1E7F, 16'h0000};
    repeat (8) @(posedge mclk);
    #1;
    chk({rd_out, alert_oe, alert_o, irq, arr_we, term_strobe_en},
        {18'h3, 5'h0});
    @(posedge mclk);
    reset_n <= 1'b1;
    repeat (3) @(posedge mclk);
    rd(`WCDM_A_MODE5, 16'h0000);
    rd(3'h6, 16'h0000);
    wr(`WCDM_A_MODE1, 16'hFFFF);
    rd(`WCDM_A_MODE1, 16'h0800);
    chk(term_strobe_en, 1'b0);
    wr(`WCDM_A_MODE1, 16'h0000);
    wr(`WCDM_A_CTRL, 16'h0001);
    wr(`WCDM_A_MODE5, 16'h0400);
    wr(`WCDM_A_MASK, 16'h0001);
    wr(`WCDM_A_STATUS, 16'h000F);
    // Masked burst, good checksum
    wb(16'h9C36, 1'b0, 1'b0, 1'b1, 1'b1);
    rd(`WCDM_A_STATUS, 16'h0002);
    wr(`WCDM_A_STATUS, 16'h000F);
    // Masked burst, bad checksum: dropped and reported
    wb(16'hFFFF, 1'b1, 1'b0, 1'b1, 1'b0);
    chk(last_alert >= 6 && last_alert <= 10, 1'b1);
    rd(`WCDM_A_MODE5, 16'h0408);
    rd(`WCDM_A_READOUT3, 16'h0080);
    rd(`WCDM_A_STATUS, 16'h0005);
    chk(irq, 1'b1);
    wr(`WCDM_A_MASK, 16'h0000);
    @(posedge mclk);
    #1;
    chk(irq, 1'b0);
    wr(`WCDM_A_MODE5, 16'h0400);
    rd(`WCDM_A_MODE5, 16'h0400);
    rd(`WCDM_A_READOUT3, 16'h0000);
    // Retry after the short alert
    wb(16'hFFFF, 1'b0, 1'b0, 1'b1, 1'b1);
    // Write inversion, bad checksum still stored
    wr(`WCDM_A_MODE5, 16'h0800);
    wb(16'h5AC2, 1'b1, 1'b1, 1'b0, 1'b1);
    // Read path: inversion, readout reads, mask only
    wr(`WCDM_A_MODE5, 16'h1000);
    rdq(1'b1, 2'h3);
    mpr_read <= 1'b1;
    rdq(1'b0, 2'h0);
    mpr_read <= 1'b0;
    wr(`WCDM_A_MODE5, 16'h0400);
    rdq(1'b0, 2'h0);
    // Mask with write inversion is flagged
    wr(`WCDM_A_MODE5, 16'h0C00);
    wr(`WCDM_A_STATUS, 16'h000F);
    rd(`WCDM_A_STATUS, 16'h0008);
    wr(`WCDM_A_MODE5, 16'h0000);
    wr(`WCDM_A_STATUS, 16'h000F);
    // Termination strobe on the narrow x8 lane pin
    org_sel <= 2'h1;
    wr(`WCDM_A_MODE1, 16'h0800);
    repeat (3) @(posedge mclk);
    #1;
    chk(term_strobe_en, 1'b1);
    wr(`WCDM_A_MODE5, 16'h0400);
    repeat (2) @(posedge mclk);
    #1;
    chk(term_strobe_en, 1'b0);
    wr(`WCDM_A_MODE1, 16'h0000);
    // Narrowest organisation never inverts
    org_sel <= 2'h0;
    wr(`WCDM_A_MODE5, 16'h1000);
    repeat (3) @(posedge mclk);
    rdq(1'b0, 2'h0);
    end_sim();
  end
endmodule : test_wcdm_lane

`default_nettype wire
